// File: cls_map.vh
// Register map, field layout and encodings of the loopback, stamp and filter block.
// Assumes a byte-addressed 8-bit register port with 32-bit data words.
`ifndef CLS_MAP_VH
`define CLS_MAP_VH

// ********************************************************************
// Register offsets
// ********************************************************************
`define CLS_ADDR_CORE_CTRL   8'h00
`define CLS_ADDR_STAMP_CFG   8'h04
`define CLS_ADDR_STAMP_VAL   8'h08
`define CLS_ADDR_TOUT_CFG    8'h0C
`define CLS_ADDR_TOUT_VAL    8'h10
`define CLS_ADDR_STATUS      8'h14
`define CLS_ADDR_EXT_MASK    8'h18
`define CLS_ADDR_PROTO_STAT  8'h1C
`define CLS_ADDR_LIST_CFG    8'h20
`define CLS_ADDR_STD_BASE    8'h40
`define CLS_ADDR_EXT_BASE    8'h80
`define CLS_NUM_FLT          4

// ********************************************************************
// Control and status fields
// ********************************************************************
`define CLS_CC_INIT          0
`define CLS_CC_MON           1
`define CLS_CC_LOOPBACK_ENABLE_EN       2
`define CLS_ST_WRAP          0
`define CLS_ST_TOUT          1
`define CLS_ST_HPRI          2
`define CLS_TO_EN            0
`define CLS_TO_SRC_LSB       1
`define CLS_TO_PER_LSB       16
`define CLS_TO_CONT          2'b00
`define CLS_TO_RXF0          2'b01
`define CLS_TO_TXEV          2'b10
`define CLS_TO_RXF1          2'b11
`define CLS_CTRL_RST         32'h0000_0001
`define CLS_TOCFG_RST        32'hFFFF_0000
`define CLS_XMASK_RST        29'h1FFF_FFFF

// ********************************************************************
// Filter element encodings
// ********************************************************************
`define CLS_FT_RANGE         2'b00
`define CLS_FT_DUAL          2'b01
`define CLS_FT_MASK          2'b10
`define CLS_FT_RANGE_NOMASK  2'b11
`define CLS_FA_OFF           3'b000
`define CLS_FA_FIFO0         3'b001
`define CLS_FA_FIFO1         3'b010
`define CLS_FA_REJECT        3'b011
`define CLS_FA_HPRI          3'b100
`define CLS_FA_HPRI_F0       3'b101
`define CLS_FA_HPRI_F1       3'b110
`define CLS_FA_BUFFER        3'b111
`define CLS_DST_NONE         2'b00
`define CLS_DST_FIFO0        2'b01
`define CLS_DST_FIFO1        2'b10
`define CLS_DST_BUF          2'b11
`define CLS_HDR_WORD         4'h0
`define CLS_STAMP_WORD       4'h1
`define CLS_DATA_WORD0       4'h2

`endif

// File: cls_top.v
// Loopback pin control, timestamp and timeout counters, and acceptance
// filtering with message store sequencing for a CAN protocol controller.
// Assumes the protocol core supplies a one-cycle sample point pulse per bit,
// frame events, the received identifier and 32-bit data words, all on sys_clk_i.
//
// Summary of operation
// - Loopback makes own transmitted frames received frames, stored if filters accept
// - External loopback feeds tx to rx internally, ignores ack errors, tx visible
// - Loopback plus monitor: rx pin disconnected, tx pin recessive
// - 16-bit wrapping stamp counter advances every 1 to 16 bit times
// - Stamp count readable; any write to stamp value register clears it
// - Stamp counter wrap sets the stamp wrap flag
// - Stamp captured at start of frame into receive or event element
// - 16-bit timeout down-counter on the same tick, readable by host
// - Timeout counter runs only while init is 0, stops at init 1
// - Continuous mode starts on init release; write reloads period
// - FIFO modes: empty FIFO holds period, count after store, writes ignored
// - Reaching zero sets timeout flag; continuous mode reloads at once
// - Timeout tick comes from the core sample point pulse
// - Separate standard and extended lists, scanned from 0, first match wins
// - Per-element enable, accept or reject, seven match actions
// - Filtering starts after full identifier; message stored in 32-bit words
// - Protocol error: no new data, no put index advance, error code kept
// - Stored identifier is the unmodified received identifier
// - Range filter; extended type 00 masks first, type 11 does not
// - Dual filter matches either field; equal fields give single id
// - Mask filter: mask 1 bits must equal, mask 0 bits ignored
// - 11-bit ids use standard list, 29-bit use extended after AND mask except type 11
`timescale 1ns/100ps
`default_nettype none
`include "cls_map.vh"

module cls_top
(
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        can_rx_i,
  output reg         can_tx_o,
  input  wire        core_tx_i,
  output reg         core_rx_o,
  input  wire        core_ack_err_i,
  output reg         core_ack_err_o,
  input  wire        sample_point_i,
  input  wire        sof_i,
  input  wire        sof_is_tx_i,
  output reg  [15:0] rx_stamp_field_o,
  output reg  [15:0] tx_event_stamp_field_o,
  input  wire [2:0]  fifo_empty_i,
  input  wire        id_valid_i,
  input  wire [28:0] id_i,
  input  wire        ide_i,
  input  wire        rtr_i,
  input  wire        word_valid_i,
  input  wire [31:0] word_i,
  input  wire        frame_ok_i,
  input  wire        frame_err_i,
  input  wire [2:0]  last_error_code_i,
  input  wire [2:0]  data_phase_error_code_i,
  output reg         mem_we_o,
  output reg  [1:0]  mem_dest_o,
  output reg  [5:0]  mem_buf_idx_o,
  output reg  [3:0]  mem_word_o,
  output reg  [31:0] mem_wdata_o,
  output reg         fifo0_put_o,
  output reg         fifo1_put_o,
  output reg         buf_new_data_o,
  output reg         filter_event_o
);

  // ********************************************************************
  // Filter compare shared by both lists
  // ********************************************************************
  function match_id;
    input [1:0]  ftype;
    input [28:0] rid;
    input [28:0] f1;
    input [28:0] f2;
    begin
      case (ftype)
        `CLS_FT_DUAL: match_id = (rid == f1) || (rid == f2);
        `CLS_FT_MASK: match_id = ((rid ^ f1) & f2) == 29'h0000_0000;
        default:      match_id = (rid >= f1) && (rid <= f2);
      endcase
    end
  endfunction

  // ********************************************************************
  // Registers
  // ********************************************************************
  reg  [31:0] core_control_reg;
  reg  [3:0]  tick_prescale;
  reg  [31:0] timeout_config_reg;
  reg  [28:0] ext_id_and_mask;
  reg  [2:0]  std_list_size;
  reg  [2:0]  ext_list_size;
  reg  [31:0] std_flt [0:`CLS_NUM_FLT-1];
  reg  [31:0] ext_flt_a [0:`CLS_NUM_FLT-1];
  reg  [31:0] ext_flt_b [0:`CLS_NUM_FLT-1];
  reg  [15:0] stamp_count;
  reg  [15:0] timeout_count;
  reg  [3:0]  presc_cnt;
  reg         stamp_wrap_flag;
  reg         timeout_flag;
  reg         high_priority_flag;
  reg  [2:0]  last_error_code;
  reg  [2:0]  data_phase_error_code;
  reg         init_q;
  reg  [31:0] next_rdata;
  integer     k;

  wire        init_bit  = core_control_reg[`CLS_CC_INIT];
  wire        mon_bit   = core_control_reg[`CLS_CC_MON];
  wire        loopback_enable_bit  = core_control_reg[`CLS_CC_LOOPBACK_ENABLE_EN];
  wire        to_en     = timeout_config_reg[`CLS_TO_EN];
  wire [1:0]  to_src    = timeout_config_reg[`CLS_TO_SRC_LSB+1:`CLS_TO_SRC_LSB];
  wire [15:0] to_period = timeout_config_reg[`CLS_TO_PER_LSB+15:`CLS_TO_PER_LSB];
  wire        wr_stamp  = reg_wr_i && (reg_addr_i == `CLS_ADDR_STAMP_VAL);
  wire        wr_tout   = reg_wr_i && (reg_addr_i == `CLS_ADDR_TOUT_VAL);
  wire        wr_status = reg_wr_i && (reg_addr_i == `CLS_ADDR_STATUS);
  wire        std_hit   = (reg_addr_i[7:4] == `CLS_ADDR_STD_BASE >> 4);
  wire        ext_hit   = (reg_addr_i[7:5] == `CLS_ADDR_EXT_BASE >> 5);

  // Configuration writes; filter elements are word-indexed flip-flops
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      core_control_reg   <= `CLS_CTRL_RST;
      tick_prescale      <= 4'h0;
      timeout_config_reg <= `CLS_TOCFG_RST;
      ext_id_and_mask    <= `CLS_XMASK_RST;
      std_list_size      <= 3'h0;
      ext_list_size      <= 3'h0;
      for (k = 0; k < `CLS_NUM_FLT; k = k + 1)
      begin
        std_flt[k]   <= 32'h0000_0000;
        ext_flt_a[k] <= 32'h0000_0000;
        ext_flt_b[k] <= 32'h0000_0000;
      end
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `CLS_ADDR_CORE_CTRL: core_control_reg   <= {29'h0000_0000, reg_wdata_i[2:0]};
        `CLS_ADDR_STAMP_CFG: tick_prescale      <= reg_wdata_i[3:0];
        `CLS_ADDR_TOUT_CFG:  timeout_config_reg <= {reg_wdata_i[31:16], 13'h0000,
                                                    reg_wdata_i[2:0]};
        `CLS_ADDR_EXT_MASK:  ext_id_and_mask    <= reg_wdata_i[28:0];
        `CLS_ADDR_LIST_CFG:
        begin
          std_list_size <= reg_wdata_i[2:0];
          ext_list_size <= reg_wdata_i[10:8];
        end
        default:
        begin
          if (std_hit && reg_addr_i[3:2] < `CLS_NUM_FLT)
            std_flt[reg_addr_i[3:2]] <= reg_wdata_i;
          else if (ext_hit && !reg_addr_i[2])
            ext_flt_a[reg_addr_i[4:3]] <= reg_wdata_i;
          else if (ext_hit)
            ext_flt_b[reg_addr_i[4:3]] <= reg_wdata_i;
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (reg_addr_i)
      `CLS_ADDR_CORE_CTRL:  next_rdata = core_control_reg;
      `CLS_ADDR_STAMP_CFG:  next_rdata = {28'h000_0000, tick_prescale};
      `CLS_ADDR_STAMP_VAL:  next_rdata = {16'h0000, stamp_count};
      `CLS_ADDR_TOUT_CFG:   next_rdata = timeout_config_reg;
      `CLS_ADDR_TOUT_VAL:   next_rdata = {16'h0000, timeout_count};
      `CLS_ADDR_STATUS:     next_rdata = {29'h0000_0000, high_priority_flag,
                                          timeout_flag, stamp_wrap_flag};
      `CLS_ADDR_EXT_MASK:   next_rdata = {3'h0, ext_id_and_mask};
      `CLS_ADDR_PROTO_STAT: next_rdata = {21'h00_0000, data_phase_error_code,
                                          5'h00, last_error_code};
      `CLS_ADDR_LIST_CFG:   next_rdata = {21'h00_0000, ext_list_size,
                                          5'h00, std_list_size};
      default:
      begin
        if (std_hit && reg_addr_i[3:2] < `CLS_NUM_FLT)
          next_rdata = std_flt[reg_addr_i[3:2]];
        else if (ext_hit && !reg_addr_i[2])
          next_rdata = ext_flt_a[reg_addr_i[4:3]];
        else if (ext_hit)
          next_rdata = ext_flt_b[reg_addr_i[4:3]];
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 32'h0000_0000;
    else
      reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0000_0000;
  end

  // ********************************************************************
  // Pin control for loopback and monitor modes
  // ********************************************************************
  // Registered so every pin leaves a flop; costs one cycle of loop delay
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      can_tx_o       <= 1'b1;
      core_rx_o      <= 1'b1;
      core_ack_err_o <= 1'b0;
    end
    else
    begin
      can_tx_o       <= mon_bit ? 1'b1 : core_tx_i;
      core_rx_o      <= loopback_enable_bit ? core_tx_i : can_rx_i;
      core_ack_err_o <= core_ack_err_i && !loopback_enable_bit;
    end
  end

  // ********************************************************************
  // Bit-time prescaler, stamp and timeout counters
  // ********************************************************************
  wire tick = sample_point_i && (presc_cnt == tick_prescale);

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      presc_cnt <= 4'h0;
    else if (tick)
      presc_cnt <= 4'h0;
    else if (sample_point_i)
      presc_cnt <= presc_cnt + 4'h1;
  end

  // Host clear beats a tick in the same cycle
  wire stamp_wraps = tick && !wr_stamp && (stamp_count == 16'hFFFF);

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      stamp_count <= 16'h0000;
    else if (wr_stamp)
      stamp_count <= 16'h0000;
    else if (tick)
      stamp_count <= stamp_count + 16'h0001;
  end

  // Stamp taken at start of frame, steered by frame direction
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_stamp_field_o       <= 16'h0000;
      tx_event_stamp_field_o <= 16'h0000;
    end
    else if (sof_i && sof_is_tx_i)
      tx_event_stamp_field_o <= stamp_count;
    else if (sof_i)
      rx_stamp_field_o <= stamp_count;
  end

  reg  fifo_empty_sel;
  wire to_hit = tick && !init_bit && to_en && (timeout_count == 16'h0001 ||
                timeout_count == 16'h0000) &&
                !(to_src == `CLS_TO_CONT && (wr_tout || init_q)) &&
                !(to_src != `CLS_TO_CONT && (fifo_empty_sel || timeout_count == 16'h0000));

  always @*
  begin
    case (to_src)
      `CLS_TO_RXF0: fifo_empty_sel = fifo_empty_i[0];
      `CLS_TO_RXF1: fifo_empty_sel = fifo_empty_i[1];
      `CLS_TO_TXEV: fifo_empty_sel = fifo_empty_i[2];
      default:      fifo_empty_sel = 1'b1;
    endcase
  end

  // Timeout down-counter; frozen while init is set
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      timeout_count <= 16'hFFFF;
      init_q        <= 1'b1;
    end
    else
    begin
      init_q <= init_bit;
      if (init_bit || !to_en)
        timeout_count <= timeout_count;
      else if (to_src == `CLS_TO_CONT)
      begin
        if (init_q || wr_tout)
          timeout_count <= to_period;
        else if (to_hit)
          timeout_count <= to_period;
        else if (tick)
          timeout_count <= timeout_count - 16'h0001;
      end
      else if (fifo_empty_sel)
        timeout_count <= to_period;
      else if (tick && timeout_count != 16'h0000)
        timeout_count <= timeout_count - 16'h0001;
    end
  end

  // ********************************************************************
  // Acceptance filter sequencer
  // ********************************************************************
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_SCAN  = 4'b0010;
  localparam [3:0] ST_STORE = 4'b0100;
  localparam [3:0] ST_SKIP  = 4'b1000;

  reg  [3:0]  state;
  reg  [2:0]  idx;
  reg  [28:0] rx_id;
  reg         rx_ide;
  reg         rx_rtr;
  reg  [3:0]  word_cnt;
  reg         hdr_done;
  reg  [1:0]  dest;
  reg  [5:0]  buf_idx;

  // Current element viewed as extended-width fields
  wire [31:0] sf     = std_flt[idx[1:0]];
  wire [31:0] ea     = ext_flt_a[idx[1:0]];
  wire [31:0] eb     = ext_flt_b[idx[1:0]];
  wire [1:0]  ftype  = rx_ide ? eb[31:30] : sf[31:30];
  wire [2:0]  action = rx_ide ? ea[31:29] : sf[29:27];
  wire [28:0] f1     = rx_ide ? ea[28:0] : {18'h0_0000, sf[26:16]};
  wire [28:0] f2     = rx_ide ? eb[28:0] : {18'h0_0000, sf[10:0]};
  wire [28:0] cmp_id = (rx_ide && ftype != `CLS_FT_RANGE_NOMASK) ?
                       (rx_id & ext_id_and_mask) : rx_id;
  wire [2:0]  lsize  = rx_ide ? ext_list_size : std_list_size;
  wire        elem_hit = (action != `CLS_FA_OFF) &&
                         match_id(ftype, cmp_id, f1, f2);
  wire        hi_pri = (action == `CLS_FA_HPRI) || (action == `CLS_FA_HPRI_F0) ||
                       (action == `CLS_FA_HPRI_F1);

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state          <= ST_IDLE;
      idx            <= 3'h0;
      rx_id          <= 29'h0000_0000;
      rx_ide         <= 1'b0;
      rx_rtr         <= 1'b0;
      dest           <= `CLS_DST_NONE;
      buf_idx        <= 6'h00;
      filter_event_o <= 1'b0;
    end
    else
    begin
      filter_event_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (id_valid_i)
          begin
            rx_id  <= id_i;
            rx_ide <= ide_i;
            rx_rtr <= rtr_i;
            idx    <= 3'h0;
            dest   <= `CLS_DST_NONE;
            state  <= ST_SCAN;
          end
        end
        ST_SCAN:
        begin
          if (idx >= lsize)
            state <= ST_SKIP;              // Nothing matched: frame rejected
          else if (elem_hit)
          begin
            case (action)
              `CLS_FA_FIFO0, `CLS_FA_HPRI_F0: dest <= `CLS_DST_FIFO0;
              `CLS_FA_FIFO1, `CLS_FA_HPRI_F1: dest <= `CLS_DST_FIFO1;
              `CLS_FA_BUFFER:
              begin
                dest           <= `CLS_DST_BUF;
                buf_idx        <= f2[5:0];
                filter_event_o <= f2[9];
              end
              default: dest <= `CLS_DST_NONE;
            endcase
            state <= (action == `CLS_FA_FIFO0 || action == `CLS_FA_FIFO1 ||
                      action == `CLS_FA_HPRI_F0 || action == `CLS_FA_HPRI_F1 ||
                      action == `CLS_FA_BUFFER) ? ST_STORE : ST_SKIP;
          end
          else
            idx <= idx + 3'h1;
        end
        ST_STORE, ST_SKIP:
        begin
          if (frame_ok_i || frame_err_i)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ********************************************************************
  // Message store in 32-bit words and frame completion
  // ********************************************************************
  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_we_o       <= 1'b0;
      mem_dest_o     <= `CLS_DST_NONE;
      mem_buf_idx_o  <= 6'h00;
      mem_word_o     <= 4'h0;
      mem_wdata_o    <= 32'h0000_0000;
      word_cnt       <= 4'h0;
      hdr_done       <= 1'b0;
      fifo0_put_o    <= 1'b0;
      fifo1_put_o    <= 1'b0;
      buf_new_data_o <= 1'b0;
    end
    else
    begin
      mem_we_o       <= 1'b0;
      fifo0_put_o    <= 1'b0;
      fifo1_put_o    <= 1'b0;
      buf_new_data_o <= 1'b0;
      mem_dest_o     <= dest;
      mem_buf_idx_o  <= buf_idx;
      if (state != ST_STORE)
      begin
        word_cnt <= `CLS_DATA_WORD0;
        hdr_done <= 1'b0;
      end
      else if (!hdr_done)
      begin
        // Header holds the id exactly as received, never the masked copy
        mem_we_o    <= 1'b1;
        mem_word_o  <= `CLS_HDR_WORD;
        mem_wdata_o <= {1'b0, rx_rtr, rx_ide,
                        rx_ide ? rx_id : {rx_id[10:0], 18'h0_0000}};
        hdr_done    <= 1'b1;
        word_cnt    <= `CLS_STAMP_WORD;
      end
      else if (word_cnt == `CLS_STAMP_WORD)
      begin
        mem_we_o    <= 1'b1;
        mem_word_o  <= `CLS_STAMP_WORD;
        mem_wdata_o <= {16'h0000, rx_stamp_field_o};
        word_cnt    <= `CLS_DATA_WORD0;
      end
      else if (frame_ok_i)
      begin
        fifo0_put_o    <= (dest == `CLS_DST_FIFO0);
        fifo1_put_o    <= (dest == `CLS_DST_FIFO1);
        buf_new_data_o <= (dest == `CLS_DST_BUF);
      end
      else if (word_valid_i && !frame_err_i)
      begin
        mem_we_o    <= 1'b1;
        mem_word_o  <= word_cnt;
        mem_wdata_o <= word_i;
        word_cnt    <= word_cnt + 4'h1;
      end
      // On frame_err_i no commit pulse: partial words stay, index unmoved
    end
  end

  // ********************************************************************
  // Status flags: hardware set wins over a write-one clear
  // ********************************************************************
  wire hpri_set = (state == ST_SCAN) && (idx < lsize) && elem_hit && hi_pri;

  always @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stamp_wrap_flag       <= 1'b0;
      timeout_flag          <= 1'b0;
      high_priority_flag    <= 1'b0;
      last_error_code       <= 3'h0;
      data_phase_error_code <= 3'h0;
    end
    else
    begin
      stamp_wrap_flag    <= stamp_wraps ||
                            (stamp_wrap_flag && !(wr_status && reg_wdata_i[`CLS_ST_WRAP]));
      timeout_flag       <= to_hit ||
                            (timeout_flag && !(wr_status && reg_wdata_i[`CLS_ST_TOUT]));
      high_priority_flag <= hpri_set ||
                            (high_priority_flag && !(wr_status && reg_wdata_i[`CLS_ST_HPRI]));
      if (frame_err_i)
      begin
        last_error_code       <= last_error_code_i;
        data_phase_error_code <= data_phase_error_code_i;
      end
    end
  end

endmodule // cls_top
`default_nettype wire

// File: cls_bus_model.sv
// Far side of the transceiver: a wired-AND bus with one other node.
// Assumes 1 is recessive and 0 dominant on every node.
`timescale 1ns/100ps
`default_nettype none
module cls_bus_model
(
  input  wire  sys_clk_i,
  input  wire  node_tx_i,
  input  wire  other_tx_i,
  output logic bus_o
);
  // One cycle of loop delay; dominant wins, so the node hears others
  always @(posedge sys_clk_i)
    bus_o <= node_tx_i & other_tx_i;
endmodule // cls_bus_model

// File: cls_top_asserts.sv
// Checker for loopback pins, stamp clear and frame commit of cls_top.
// Assumes it is bound into cls_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cls_checker
(
  input wire        sys_clk_i,
  input wire        rst_n_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire        can_rx_i,
  input wire        can_tx_o,
  input wire        core_tx_i,
  input wire        core_rx_o,
  input wire        core_ack_err_o,
  input wire        frame_err_i,
  input wire        fifo0_put_o,
  input wire        fifo1_put_o,
  input wire        buf_new_data_o,
  input wire        mem_we_o,
  input wire [1:0]  mem_dest_o
);
  logic lb;
  logic mon;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of the loopback and monitor bits, updated with the register
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      {lb, mon} <= 2'b00;
    else if (reg_wr_i && reg_addr_i == 8'h00)
      {lb, mon} <= reg_wdata_i[2:1];
  property p_ext_rx; $past(lb) |-> core_rx_o == $past(core_tx_i); endproperty
  a_ext_rx: assert property (p_ext_rx) else $error("rx not fed from tx");
  property p_ext_tx; $past(lb) && !$past(mon) |-> can_tx_o == $past(core_tx_i); endproperty
  a_ext_tx: assert property (p_ext_tx) else $error("tx pin hidden");
  property p_ack; $past(lb) |-> !core_ack_err_o; endproperty
  a_ack: assert property (p_ack) else $error("ack error passed");
  property p_pin_rx; !$past(lb) |-> core_rx_o == $past(can_rx_i); endproperty
  a_pin_rx: assert property (p_pin_rx) else $error("rx pin not followed");
  property p_int_tx; $past(lb) && $past(mon) |-> can_tx_o; endproperty
  a_int_tx: assert property (p_int_tx) else $error("tx pin not recessive");
  property p_clr;
    $past(reg_wr_i) && $past(reg_addr_i) == 8'h08 && reg_rd_i && reg_addr_i == 8'h08
    |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_clr: assert property (p_clr) else $error("stamp not cleared");
  property p_err; frame_err_i |=> !(fifo0_put_o || fifo1_put_o || buf_new_data_o); endproperty
  a_err: assert property (p_err) else $error("discarded frame committed");
  property p_dest; mem_we_o |-> mem_dest_o != 2'b00; endproperty
  a_dest: assert property (p_dest) else $error("store without target");
endmodule // cls_checker
bind cls_top cls_checker u_chk (.*);
`default_nettype wire

// File: can_loopback_stamp_filter_tb.sv
// Self-checking bench for cls_top: register tasks, pins, counters, filters.
// Assumes the bus model closes the CAN pin loop.
`timescale 1ns/100ps
`default_nettype none
`include "cls_map.vh"
module can_loopback_stamp_filter_tb;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ctx = 1'b1, oth = 1'b1, aerr = 1'b1;
  logic sp = 1'b0, sof = 1'b0, idv = 1'b0, wv = 1'b0, fok = 1'b0, ferr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, wd = 32'h0000_0000, rdata, mem_wd;
  logic [28:0] idw = 29'h0000_0000;
  logic [2:0] fempty = 3'b111;
  logic [3:0] mem_word;
  logic tx, bus, crx, aerr_o, mem_we, f0put;
  int n_fail = 0, total_checks = 0;
  always #5 clk = ~clk;
  cls_bus_model u_bus (.sys_clk_i(clk), .node_tx_i(tx), .other_tx_i(oth), .bus_o(bus));
  cls_top u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .can_rx_i(bus), .can_tx_o(tx),
    .core_tx_i(ctx), .core_rx_o(crx), .core_ack_err_i(aerr), .core_ack_err_o(aerr_o),
    .sample_point_i(sp), .sof_i(sof), .sof_is_tx_i(1'b0), .rx_stamp_field_o(),
    .tx_event_stamp_field_o(), .fifo_empty_i(fempty), .id_valid_i(idv), .id_i(idw),
    .ide_i(1'b0), .rtr_i(1'b0), .word_valid_i(wv), .word_i(wd), .frame_ok_i(fok),
    .frame_err_i(ferr), .last_error_code_i(3'b000), .data_phase_error_code_i(3'b000),
    .mem_we_o(mem_we), .mem_dest_o(), .mem_buf_idx_o(), .mem_word_o(mem_word),
    .mem_wdata_o(mem_wd), .fifo0_put_o(f0put), .fifo1_put_o(), .buf_new_data_o(),
    .filter_event_o());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One-cycle strobes; a read may follow a write with no idle cycle
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      sp <= 1'b1;
      @(posedge clk);
      sp <= 1'b0;
    end
  endtask
  // Drive both tx sources, then look at pin, core rx and ack error
  task automatic pin(input logic t, o, et, er, ea);
    @(posedge clk);
    ctx <= t;
    oth <= o;
    repeat (4) @(posedge clk);
    #1 chk({29'h0, tx, crx, aerr_o}, {29'h0, et, er, ea});
  endtask
  // Bounded look for the header word; no open-ended wait
  task automatic frame(input logic [10:0] id, input logic ok, hit);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    idv <= 1'b1;
    idw <= {18'h0_0000, id};
    @(posedge clk);
    idv <= 1'b0;
    repeat (8)
    begin
      @(posedge clk);
      #1 if (mem_we && mem_word == `CLS_HDR_WORD)
      begin
        seen = 1'b1;
        chk(mem_wd, {3'b000, id, 18'h0_0000});
      end
    end
    chk(32'(seen), 32'(hit));
    @(posedge clk);
    wv <= 1'b1;
    wd <= 32'hA5A5_5A5A;
    @(posedge clk);
    wv <= 1'b0;
    fok <= ok;
    ferr <= !ok;
    @(posedge clk);
    fok <= 1'b0;
    ferr <= 1'b0;
    #1 chk(32'(f0put), 32'(hit && ok));
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`CLS_ADDR_CORE_CTRL, `CLS_CTRL_RST);
    rreg(`CLS_ADDR_TOUT_CFG, `CLS_TOCFG_RST);
    rreg(`CLS_ADDR_EXT_MASK, {3'b000, `CLS_XMASK_RST});
    rreg(8'h3C, 32'h0000_0000);
    wreg(`CLS_ADDR_CORE_CTRL, 32'h0000_0000);
    pin(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    wreg(`CLS_ADDR_CORE_CTRL, 32'h0000_0004);
    pin(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    pin(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    wreg(`CLS_ADDR_CORE_CTRL, 32'h0000_0006);
    pin(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    pin(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    wreg(`CLS_ADDR_CORE_CTRL, 32'h0000_0000);
    wreg(`CLS_ADDR_TOUT_CFG, 32'h0005_0001);
    wreg(`CLS_ADDR_TOUT_VAL, 32'h0000_0000);
    tick(3);
    rreg(`CLS_ADDR_TOUT_VAL, 32'h0000_0002);
    wreg(`CLS_ADDR_CORE_CTRL, 32'h0000_0001);
    tick(2);
    rreg(`CLS_ADDR_TOUT_VAL, 32'h0000_0002);
    wreg(`CLS_ADDR_CORE_CTRL, 32'h0000_0000);
    tick(5);
    rreg(`CLS_ADDR_STATUS, 32'h0000_0002);
    wreg(`CLS_ADDR_TOUT_CFG, 32'h0005_0003);
    tick(2);
    wreg(`CLS_ADDR_TOUT_VAL, 32'h0000_0000);
    rreg(`CLS_ADDR_TOUT_VAL, 32'h0000_0005);
    @(posedge clk) fempty <= 3'b110;
    tick(2);
    rreg(`CLS_ADDR_TOUT_VAL, 32'h0000_0003);
    wreg(`CLS_ADDR_STAMP_CFG, 32'h0000_0001);
    wreg(`CLS_ADDR_STAMP_VAL, 32'h0000_0000);
    rreg(`CLS_ADDR_STAMP_VAL, 32'h0000_0000);
    tick(6);
    rreg(`CLS_ADDR_STAMP_VAL, 32'h0000_0003);
    wreg(`CLS_ADDR_LIST_CFG, 32'h0000_0001);
    wreg(`CLS_ADDR_STD_BASE, 32'h4923_0123);
    frame(11'h123, 1'b1, 1'b1);
    frame(11'h124, 1'b1, 1'b0);
    frame(11'h123, 1'b0, 1'b1);
    finish_test();
  end
endmodule // can_loopback_stamp_filter_tb
`default_nettype wire
